// ---- hw/sse_dmem.sv ----
// byte-wide data memory, asynchronous read, synchronous write
`timescale 1ns/100ps
module sse_dmem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic  i_clk,
  sse_mem_if.mem     mem
);
  logic [7:0] store [DEPTH];

  assign mem.rdata = store[mem.raddr];

  // no reset: contents are undefined until software loads them
  always_ff @(posedge i_clk) begin
    if (mem.we) begin
      store[mem.waddr] <= mem.wdata;
    end
  end
endmodule : sse_dmem

// ---- hw/sse_exec.sv ----
// skip/subtract instruction executor with AHB-Lite register slave
// ****************************************
// ****************************************
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "sse_map.svh"
module sse_exec #(
  parameter int DEPTH   = 16,
  parameter int AW      = 4,
  parameter int CYC_DIV = `SSE_CYC_DIV
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_busy
);
  import sse_pkg::*;

  localparam int CW = (CYC_DIV > 1) ? $clog2(CYC_DIV) : 1;

  // ****************************************
  // address decode
  // ****************************************
  function automatic sse_sel_t dec_sel(input logic [31:0] a);
    if (a[7:0] == `SSE_OFS_CMD) begin
      dec_sel = SSE_SEL_CMD;
    end else if (a[7:0] == `SSE_OFS_ACCUM) begin
      dec_sel = SSE_SEL_ACCUM;
    end else if (a[7:0] == `SSE_OFS_FLAGS) begin
      dec_sel = SSE_SEL_FLAGS;
    end else if (a[7:0] == `SSE_OFS_STATUS) begin
      dec_sel = SSE_SEL_STATUS;
    end else if (a[7:0] >= `SSE_OFS_MEM_BASE && {1'b0, a[7:2]} < 7'(16 + DEPTH)) begin
      dec_sel = SSE_SEL_MEM;
    end else begin
      dec_sel = SSE_SEL_NONE;
    end
  endfunction : dec_sel

  sse_mem_if #(.AW(AW)) mif ();
  sse_dmem #(.DEPTH(DEPTH), .AW(AW)) u_dmem (
    .i_clk (i_clk),
    .mem   (mif.mem)
  );

  sse_state_t    st_reg, st_next;
  sse_op_t       op_reg;
  logic [2:0]    bit_reg;
  logic [AW-1:0] addr_reg;
  logic [7:0]    opnd_reg;
  logic [7:0]    accumulator_reg;
  logic [5:0]    flags_reg;
  logic [7:0]    pc_reg;
  logic [CW-1:0] div_reg;
  logic          dph_wr_reg;
  sse_sel_t      dph_sel_reg;
  logic [AW-1:0] dph_idx_reg;
  logic [31:0]   hrdata_reg;

  // ****************************************
  // bus side
  // ****************************************
  wire           aph_valid = i_hsel & i_htrans[1] & i_hready;
  wire sse_sel_t aph_sel   = dec_sel(i_haddr);
  wire [AW-1:0]  aph_idx   = i_haddr[AW+1:2];
  wire           idle      = (st_reg == SSE_ST_IDLE);
  // software writes land only while idle, so a running instruction sees stable state
  wire           bus_wr    = dph_wr_reg & idle;
  wire           cmd_go    = bus_wr & (dph_sel_reg == SSE_SEL_CMD);
  wire           accum_bwr = bus_wr & (dph_sel_reg == SSE_SEL_ACCUM);
  wire           flg_bwr   = bus_wr & (dph_sel_reg == SSE_SEL_FLAGS);
  wire           mem_bwr   = bus_wr & (dph_sel_reg == SSE_SEL_MEM);
  // forward a byte written in the previous data phase to a read of the same word
  wire           fwd_hit   = mem_bwr & (dph_idx_reg == aph_idx);
  wire [7:0]     mem_rd    = fwd_hit ? i_hwdata[7:0] : mif.rdata;
  wire [31:0]    sts_word  = {16'h0000, pc_reg, 7'h00, ~idle};
  wire [31:0]    rd_mux    = (aph_sel == SSE_SEL_ACCUM)  ? {24'h000000, accumulator_reg} :
                             (aph_sel == SSE_SEL_FLAGS)  ? {26'h0, flags_reg} :
                             (aph_sel == SSE_SEL_STATUS) ? sts_word :
                             (aph_sel == SSE_SEL_MEM && idle) ? {24'h000000, mem_rd} :
                             32'h00000000;

  assign o_hrdata    = hrdata_reg;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_busy      = ~idle;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dph_wr_reg  <= 1'b0;
      dph_sel_reg <= SSE_SEL_NONE;
      dph_idx_reg <= '0;
      hrdata_reg  <= 32'h00000000;
    end else begin
      dph_wr_reg  <= aph_valid & i_hwrite;
      dph_sel_reg <= aph_sel;
      dph_idx_reg <= aph_idx;
      if (aph_valid && !i_hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // ****************************************
  // instruction cycle enable
  // ****************************************
  wire cyc_en = (div_reg == CW'(CYC_DIV - 1)) || (CYC_DIV < 2);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= cyc_en ? '0 : CW'(div_reg + 1'b1);
    end
  end

  // ****************************************
  // execute datapath
  // ****************************************
  wire [7:0] inc_val  = 8'(opnd_reg + 8'h01);
  wire [8:0] sub_full = {1'b0, accumulator_reg} - {1'b0, opnd_reg};
  wire [7:0] diff     = sub_full[7:0];
  wire       sub_ovf  = (accumulator_reg[7] ^ opnd_reg[7]) & (diff[7] ^ accumulator_reg[7]);
  wire       sub_z    = (diff == 8'h00);
  wire [5:0] sub_flg;
  assign sub_flg[`SSE_FLG_C]    = ~sub_full[8];
  assign sub_flg[`SSE_FLG_AUXC] = (accumulator_reg[3:0] >= opnd_reg[3:0]);
  assign sub_flg[`SSE_FLG_Z]    = sub_z;
  assign sub_flg[`SSE_FLG_OVF]  = sub_ovf;
  assign sub_flg[`SSE_FLG_SGN]  = sub_ovf ^ diff[7];
  assign sub_flg[`SSE_FLG_CHZ]  = sub_z;

  wire skip_w = (op_reg == SSE_OP_INC_SKZ)  ? (inc_val == 8'h00) :
                (op_reg == SSE_OP_BIT_SKNZ) ? opnd_reg[bit_reg] :
                (op_reg == SSE_OP_BYT_SKNZ) ? (opnd_reg != 8'h00) :
                1'b0;
  wire exec_now = (st_reg == SSE_ST_EXEC) & cyc_en;
  wire accum_xwr = exec_now & ((op_reg == SSE_OP_INC_SKZ) | (op_reg == SSE_OP_SUB));
  // byte test rewrites the same value; the other three leave memory alone
  wire mem_xwr  = exec_now & (op_reg == SSE_OP_BYT_SKNZ);

  assign mif.raddr = idle ? aph_idx : addr_reg;
  assign mif.waddr = idle ? dph_idx_reg : addr_reg;
  assign mif.we    = mem_bwr | mem_xwr;
  assign mif.wdata = idle ? i_hwdata[7:0] : opnd_reg;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      SSE_ST_IDLE: begin
        if (cmd_go) begin
          st_next = SSE_ST_READ;
        end
      end
      SSE_ST_READ: begin
        if (cyc_en) begin
          st_next = SSE_ST_EXEC;
        end
      end
      SSE_ST_EXEC: begin
        if (cyc_en) begin
          st_next = skip_w ? SSE_ST_DUMMY : SSE_ST_IDLE;
        end
      end
      default: begin
        if (cyc_en) begin
          st_next = SSE_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg   <= SSE_ST_IDLE;
      op_reg   <= SSE_OP_INC_SKZ;
      bit_reg  <= 3'h0;
      addr_reg <= '0;
    end else begin
      st_reg <= st_next;
      if (cmd_go) begin
        op_reg   <= sse_op_t'(i_hwdata[`SSE_CMD_OP_MSB:`SSE_CMD_OP_LSB]);
        bit_reg  <= i_hwdata[`SSE_CMD_BIT_MSB:`SSE_CMD_BIT_LSB];
        addr_reg <= i_hwdata[`SSE_CMD_ADDR_LSB+AW-1:`SSE_CMD_ADDR_LSB];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opnd_reg <= 8'h00;
    end else if (st_reg == SSE_ST_READ && cyc_en) begin
      opnd_reg <= mif.rdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      accumulator_reg <= `SSE_ACCUM_RST;
    end else if (accum_xwr) begin
      accumulator_reg <= (op_reg == SSE_OP_SUB) ? diff : inc_val;
    end else if (accum_bwr) begin
      accumulator_reg <= i_hwdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg <= `SSE_FLAGS_RST;
    end else if (exec_now && op_reg == SSE_OP_SUB) begin
      flags_reg <= sub_flg;
    end else if (flg_bwr) begin
      flags_reg <= i_hwdata[5:0];
    end
  end

  // the dummy slot only steps the counter past the skipped instruction
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_reg <= `SSE_PC_RST;
    end else if (cyc_en && (st_reg == SSE_ST_EXEC || st_reg == SSE_ST_DUMMY)) begin
      pc_reg <= 8'(pc_reg + 8'h01);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_exec(sse_op_t o);
    st_reg == SSE_ST_EXEC && cyc_en && op_reg == o;
  endsequence
  sequence s_skip_taken;
    st_reg == SSE_ST_EXEC && cyc_en && skip_w;
  endsequence
  // the lower bound of zero keeps this valid when the divider runs at full rate
  sequence s_dummy_done;
    ##[0:16] (st_reg == SSE_ST_DUMMY && cyc_en) ##1 (st_reg == SSE_ST_IDLE);
  endsequence

  a_inc_accum_value: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_exec(SSE_OP_INC_SKZ) |=> accumulator_reg == 8'($past(opnd_reg) + 8'h01) && !$past(mif.we))
    else $error("increment result wrong or memory written");
  a_inc_skip_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_exec(SSE_OP_INC_SKZ) |=> (st_reg == SSE_ST_DUMMY) == (accumulator_reg == 8'h00))
    else $error("increment skip does not follow zero result");
  a_skip_three_cycles: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_skip_taken |=> (st_reg == SSE_ST_DUMMY) ##0 s_dummy_done)
    else $error("taken skip did not spend one dummy cycle");
  a_bit_skip_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_exec(SSE_OP_BIT_SKNZ) |=> (st_reg == SSE_ST_DUMMY) == $past(skip_w)
      && (st_reg == SSE_ST_DUMMY) == opnd_reg[bit_reg])
    else $error("bit test skip wrong");
  a_byte_write_back: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_exec(SSE_OP_BYT_SKNZ) |-> mif.we && mif.wdata == opnd_reg && mif.waddr == addr_reg
      ##1 (st_reg == SSE_ST_DUMMY) == ($past(opnd_reg) != 8'h00))
    else $error("byte test write-back or skip wrong");
  a_byte_zero_noskip: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_exec(SSE_OP_BYT_SKNZ) ##0 (opnd_reg == 8'h00) |=> st_reg == SSE_ST_IDLE)
    else $error("zero byte caused a skip");
  a_sub_difference: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_exec(SSE_OP_SUB) |-> !mif.we
      ##1 accumulator_reg == 8'($past(accumulator_reg) - $past(opnd_reg)))
    else $error("subtract result wrong or memory written");
  a_sub_carry_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_exec(SSE_OP_SUB) |=> flags_reg[`SSE_FLG_C] == ($past(accumulator_reg) >= $past(opnd_reg)))
    else $error("carry does not reflect borrow");
  a_sub_zero_flags: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_exec(SSE_OP_SUB) |=> flags_reg[`SSE_FLG_Z] == (accumulator_reg == 8'h00)
      && flags_reg[`SSE_FLG_CHZ] == flags_reg[`SSE_FLG_Z])
    else $error("zero flags do not match result");
  a_dummy_no_effect: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_reg == SSE_ST_DUMMY |-> !mif.we ##1 $stable(accumulator_reg) && $stable(flags_reg))
    else $error("skipped slot changed state");

endmodule : sse_exec

// ---- hw/sse_map.svh ----
// register offsets, field positions, reset values and timing counts of the skip/subtract executor
`ifndef SSE_MAP_SVH
`define SSE_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SSE_OFS_CMD      8'h00
`define SSE_OFS_ACCUM    8'h04
`define SSE_OFS_FLAGS    8'h08
`define SSE_OFS_STATUS   8'h0c
`define SSE_OFS_MEM_BASE 8'h40

// ****************************************
// field positions
// ****************************************
`define SSE_CMD_OP_LSB   0
`define SSE_CMD_OP_MSB   1
`define SSE_CMD_BIT_LSB  4
`define SSE_CMD_BIT_MSB  6
`define SSE_CMD_ADDR_LSB 8
`define SSE_CMD_ADDR_MSB 11
`define SSE_FLG_C        0
`define SSE_FLG_AUXC     1
`define SSE_FLG_Z        2
`define SSE_FLG_OVF      3
`define SSE_FLG_SGN      4
`define SSE_FLG_CHZ      5
`define SSE_STS_BUSY     0
`define SSE_STS_PC_LSB   8
`define SSE_STS_PC_MSB   15

// ****************************************
// reset values and timing
// ****************************************
`define SSE_ACCUM_RST    8'h00
`define SSE_FLAGS_RST    6'h00
`define SSE_PC_RST       8'h00
`define SSE_CYC_DIV      4

`endif

// ---- hw/sse_mem_if.sv ----
// data memory port between the executor and its byte store
`timescale 1ns/100ps
interface sse_mem_if #(parameter int AW = 4);
  logic [AW-1:0] raddr;
  logic [7:0]    rdata;
  logic [AW-1:0] waddr;
  logic          we;
  logic [7:0]    wdata;
  modport exec (output raddr, output waddr, output we, output wdata, input rdata);
  modport mem  (input raddr, input waddr, input we, input wdata, output rdata);
endinterface : sse_mem_if

// ---- hw/sse_pkg.sv ----
// types shared by the skip/subtract executor
package sse_pkg;

  typedef enum logic [1:0] {
    SSE_OP_INC_SKZ  = 2'h0,
    SSE_OP_BIT_SKNZ = 2'h1,
    SSE_OP_BYT_SKNZ = 2'h2,
    SSE_OP_SUB      = 2'h3
  } sse_op_t;

  // gray coded along idle -> read -> exec -> dummy -> idle
  typedef enum logic [1:0] {
    SSE_ST_IDLE  = 2'h0,
    SSE_ST_READ  = 2'h1,
    SSE_ST_EXEC  = 2'h3,
    SSE_ST_DUMMY = 2'h2
  } sse_state_t;

  typedef enum logic [2:0] {
    SSE_SEL_NONE   = 3'h0,
    SSE_SEL_CMD    = 3'h1,
    SSE_SEL_ACCUM  = 3'h2,
    SSE_SEL_FLAGS  = 3'h3,
    SSE_SEL_STATUS = 3'h4,
    SSE_SEL_MEM    = 3'h5
  } sse_sel_t;

endpackage : sse_pkg

// ---- testbench/skip_subtract_exec_tb.sv ----
// self-checking bench for the skip/subtract executor
`timescale 1ns/100ps
`include "sse_map.svh"
module skip_subtract_exec_tb;
  import sse_pkg::*;
  localparam int         CYC     = 4;
  localparam logic [5:0] FLG_PRE = 6'h2a;
  logic        i_clk   = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        busy;
  int          n_fail    = 0;
  int          cmp_count = 0;
  int          cyc       = 0;

  always #25 i_clk = ~i_clk;

  sse_exec #(.CYC_DIV(CYC)) i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hready), .i_hwdata(hwdata),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_busy(busy)
  );

  sse_ahb_host i_host (
    .i_clk(i_clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
    .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata)
  );

  // ****************************************
  // checking and bus helpers
  // ****************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    i_host.xfer(1'b1, {24'h0, a}, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    i_host.xfer(1'b0, {24'h0, a}, 32'h0, d);
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    chk(r, exp);
  endtask : rchk

  function automatic logic [7:0] mem_ofs(input logic [3:0] n);
    return `SSE_OFS_MEM_BASE + {2'b00, n, 2'b00};
  endfunction : mem_ofs

  // one instruction from a known state; the accumulator is also written while busy
  // to see that write dropped
  task automatic op_case(input sse_op_t op, input logic [2:0] bi, input logic [3:0] ma,
                         input logic [7:0] mem_in, input logic [7:0] accum_in,
                         input logic [7:0] accum_exp, input logic [5:0] flg_exp,
                         input logic skip);
    logic [31:0] st0;
    logic [31:0] st;
    int          n;
    wr(mem_ofs(ma), {24'h0, mem_in});
    wr(`SSE_OFS_ACCUM, {24'h0, accum_in});
    wr(`SSE_OFS_FLAGS, {26'h0, FLG_PRE});
    rd(`SSE_OFS_STATUS, st0);
    wr(`SSE_OFS_CMD, {20'h0, ma, 1'b0, bi, 2'b00, op});
    #1;
    chk({31'h0, busy}, 32'h1);
    wr(`SSE_OFS_ACCUM, 32'h5a);
    n = 0;
    do begin
      rd(`SSE_OFS_STATUS, st);
      n++;
    end while (st[0] !== 1'b0 && n < 50);
    chk({24'h0, st[15:8]}, {24'h0, st0[15:8] + (skip ? 8'h2 : 8'h1)});
    rchk(`SSE_OFS_ACCUM, {24'h0, accum_exp});
    rchk(mem_ofs(ma), {24'h0, mem_in});
    rchk(`SSE_OFS_FLAGS, {26'h0, flg_exp});
  endtask : op_case

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hready}, 32'h1);
    rchk(`SSE_OFS_ACCUM, 32'h0);
    rchk(`SSE_OFS_FLAGS, 32'h0);
    rchk(`SSE_OFS_STATUS, 32'h0);
    rchk(`SSE_OFS_CMD, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rchk(8'h20, 32'h0);
    op_case(SSE_OP_INC_SKZ, 3'h0, 4'h3, 8'hff, 8'h11, 8'h00, FLG_PRE, 1'b1);
    op_case(SSE_OP_INC_SKZ, 3'h0, 4'h4, 8'h41, 8'h11, 8'h42, FLG_PRE, 1'b0);
    op_case(SSE_OP_BIT_SKNZ, 3'h5, 4'h5, 8'h20, 8'h11, 8'h11, FLG_PRE, 1'b1);
    op_case(SSE_OP_BIT_SKNZ, 3'h4, 4'h5, 8'h20, 8'h11, 8'h11, FLG_PRE, 1'b0);
    op_case(SSE_OP_BYT_SKNZ, 3'h0, 4'h6, 8'h00, 8'h11, 8'h11, FLG_PRE, 1'b0);
    op_case(SSE_OP_BYT_SKNZ, 3'h0, 4'hf, 8'h80, 8'h11, 8'h11, FLG_PRE, 1'b1);
    op_case(SSE_OP_SUB, 3'h0, 4'h7, 8'h20, 8'h10, 8'hf0, 6'h12, 1'b0);
    op_case(SSE_OP_SUB, 3'h0, 4'h8, 8'h01, 8'h80, 8'h7f, 6'h19, 1'b0);
    op_case(SSE_OP_SUB, 3'h0, 4'h9, 8'h33, 8'h33, 8'h00, 6'h27, 1'b0);
    conclude();
  end
endmodule : skip_subtract_exec_tb

// ---- testbench/sse_ahb_host.sv ----
// bus master model that issues single-word AHB-Lite transfers to the executor
`timescale 1ns/100ps
module sse_ahb_host (
  input  wire logic        i_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic      [31:0] o_haddr,
  output logic      [1:0]  o_htrans,
  output logic             o_hwrite,
  output logic      [2:0]  o_hsize,
  output logic      [31:0] o_hwdata
);
  initial begin
    o_hsel   = 1'b0;
    o_haddr  = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize  = 3'h2;
    o_hwdata = 32'h0;
  end

  // ****************************************
  // one transfer: address phase, then data phase
  // ****************************************
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    @(posedge i_clk);
    o_hsel   <= 1'b1;
    o_haddr  <= addr;
    o_htrans <= 2'h2;
    o_hwrite <= wr;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    o_htrans <= 2'h0;
    // a read data phase carries junk so stale write data cannot look valid
    o_hwdata <= wr ? wdata : ~wdata;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    rdata = i_hrdata;
  endtask : xfer
endmodule : sse_ahb_host
